// [inc/rpm_pkg.sv]
// Constants and types of the receive path overhead monitor
package rpm_pkg;

  // ****************************************************
  // Register offsets
  // ****************************************************
  localparam logic [7:0] A_BLOCK_SIZE = 8'h68;
  localparam logic [7:0] A_WINDOW = 8'h69;
  localparam logic [7:0] A_THRESH = 8'h6a;
  localparam logic [7:0] A_DECLARE = 8'h6b;
  localparam logic [7:0] A_CLEAR = 8'h6c;
  localparam logic [7:0] A_ACC_LABEL = 8'h6d;
  localparam logic [7:0] A_FEBE_LO = 8'hd2;
  localparam logic [7:0] A_FEBE_HI = 8'hd3;
  localparam logic [7:0] A_B3_LO = 8'hd4;
  localparam logic [7:0] A_B3_HI = 8'hd5;
  localparam logic [7:0] A_EXPECT = 8'he4;
  localparam logic [7:0] A_SR3 = 8'he8;
  localparam logic [7:0] A_SR6 = 8'hea;
  localparam logic [7:0] A_SR7 = 8'hf6;
  localparam logic [7:0] A_CR6 = 8'hfe;
  localparam logic [7:0] A_CONTROL_REG_SIXTEEN = 8'hff;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int SR3_MF_LOSS = 0;
  localparam int SR3_UNEQ = 1;
  localparam int SR3_MISMATCH = 2;
  localparam int SR3_EBER = 4;
  localparam int SR6_PDI = 4;
  localparam int SR7_FEBE_OVF = 4;
  localparam int SR7_B3_OVF = 7;
  localparam int CR6_LOCAL_MF = 5;
  localparam int CONTROL_REG_SIXTEEN_WIDE = 7;

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [7:0] RST_BLOCK_SIZE = 8'h05;
  localparam logic [7:0] RST_WINDOW = 8'h40;
  localparam logic [7:0] RST_THRESH = 8'h42;
  localparam logic [7:0] RST_DECLARE = 8'h10;
  localparam logic [7:0] RST_CLEAR = 8'h1d;
  localparam logic [7:0] RST_EXPECT = 8'h00;
  localparam logic [7:0] RST_CR6 = 8'h00;
  localparam logic [7:0] RST_CONTROL_REG_SIXTEEN = 8'h01;

  // ****************************************************
  // Label values and counts
  // ****************************************************
  localparam logic [7:0] LABEL_UNEQ = 8'h00;
  localparam logic [7:0] LABEL_PDI_LO = 8'he1;
  localparam logic [7:0] LABEL_PDI_HI = 8'hfc;
  localparam logic [2:0] LABEL_REPEATS = 3'h4;
  localparam logic [3:0] FAR_END_MAX = 4'h8;
  localparam logic [15:0] CNT_MAX_NARROW = 16'h00ff;
  localparam logic [15:0] CNT_MAX_WIDE = 16'hffff;

  typedef enum logic [1:0] {MF_OFF, MF_SYNC, MF_LOSS} rpm_mf_e;

endpackage : rpm_pkg

// [hw/rpm_monitor.sv]
// Receive path overhead monitor: parity, label, multiframe, far-end
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps

module rpm_monitor
  import rpm_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic frame_start,
  input wire logic spe_valid,
  input wire logic [7:0] spe_data,
  input wire logic b3_valid,
  input wire logic [7:0] b3_data,
  input wire logic c2_valid,
  input wire logic [7:0] c2_data,
  input wire logic h4_valid,
  input wire logic [7:0] h4_data,
  input wire logic g1_valid,
  input wire logic [7:0] g1_data,
  input wire logic line_defect,
  input wire logic path_defect,
  output logic far_end_err_stb,
  output logic [3:0] far_end_err_count,
  output logic h4_out_valid,
  output logic [7:0] h4_out,
  output logic [1:0] mf_phase,
  output logic mf_v1_en,
  output logic excess_path_error_alarm,
  output logic label_mismatch_alarm,
  output logic unequipped_label_alarm,
  output logic payload_defect_label_alarm,
  output logic multiframe_loss_alarm
);

  // ****************************************************
  // Functions
  // ****************************************************
  function automatic logic [16:0] sat_add(input logic [15:0] cur,
                                          input logic [3:0] inc,
                                          input logic wide);
    logic [15:0] top;
    top = wide ? CNT_MAX_WIDE : CNT_MAX_NARROW;
    if ((17'(cur) + 17'(inc)) > 17'(top)) begin
      sat_add = {1'b1, top};
    end else begin
      sat_add = {1'b0, cur + 16'(inc)};
    end
  endfunction : sat_add

  function automatic logic [23:0] pow10(input logic [2:0] e);
    pow10 = 24'h000001;
    for (int i = 0; i < 7; i++) begin
      if (i < int'(e)) begin
        pow10 = 24'(pow10 * 24'h00000a);
      end
    end
  endfunction : pow10

  // ****************************************************
  // State
  // ****************************************************
  logic [7:0] block_size_reg, block_size_next;
  logic [7:0] window_reg, window_next;
  logic [7:0] thresh_reg, thresh_next;
  logic [7:0] declare_reg, declare_next;
  logic [7:0] clear_reg, clear_next;
  logic [7:0] expect_reg, expect_next;
  logic [7:0] cr6_reg, cr6_next;
  logic [7:0] control_reg_sixteen_reg, control_reg_sixteen_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [15:0] b3_cnt_reg, b3_cnt_next;
  logic [15:0] febe_cnt_reg, febe_cnt_next;
  logic b3_ovf_reg, b3_ovf_next;
  logic febe_ovf_reg, febe_ovf_next;
  logic [7:0] bip_acc_reg, bip_acc_next;
  logic [7:0] bip_prev_reg, bip_prev_next;
  logic bip_ok_reg, bip_ok_next;
  logic stb_reg, stb_next;
  logic [3:0] errs_reg, errs_next;
  logic [27:0] frame_cnt_reg, frame_cnt_next;
  logic [7:0] blk_err_reg, blk_err_next;
  logic [7:0] blk_cnt_reg, blk_cnt_next;
  logic [7:0] bad_cnt_reg, bad_cnt_next;
  logic [7:0] good_cnt_reg, good_cnt_next;
  logic eber_reg, eber_next;
  logic [7:0] cand_reg, cand_next;
  logic [2:0] rep_reg, rep_next;
  logic [7:0] label_reg, label_next;
  logic label_ok_reg, label_ok_next;
  rpm_mf_e mf_state_reg, mf_state_next;
  logic [1:0] mf_cnt_reg, mf_cnt_next;
  logic [1:0] mf_cand_reg, mf_cand_next;
  logic h4v_reg, h4v_next;
  logic [7:0] h4_reg, h4_next;

  logic inhibit, wide, local_mf, wr_b3, wr_febe, rd_sr7;
  logic uneq, pdi, mism, bad, good;
  logic [3:0] diff_pop, febe_inc;
  logic [7:0] diff, blk_sum;
  logic [8:0] blk_wide;
  logic [16:0] b3_add, febe_add;
  logic [27:0] blk_len;

  // ****************************************************
  // Register file
  // ****************************************************
  always_comb begin
    block_size_next = block_size_reg;
    window_next = window_reg;
    thresh_next = thresh_reg;
    declare_next = declare_reg;
    clear_next = clear_reg;
    expect_next = expect_reg;
    cr6_next = cr6_reg;
    control_reg_sixteen_next = control_reg_sixteen_reg;
    rdata_next = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        A_BLOCK_SIZE: block_size_next = {4'h0, reg_wdata[3:0]};
        A_WINDOW: window_next = reg_wdata;
        A_THRESH: thresh_next = reg_wdata;
        A_DECLARE: declare_next = reg_wdata;
        A_CLEAR: clear_next = reg_wdata;
        A_EXPECT: expect_next = reg_wdata;
        A_CR6: cr6_next = reg_wdata;
        A_CONTROL_REG_SIXTEEN: control_reg_sixteen_next = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        A_BLOCK_SIZE: rdata_next = block_size_reg;
        A_WINDOW: rdata_next = window_reg;
        A_THRESH: rdata_next = thresh_reg;
        A_DECLARE: rdata_next = declare_reg;
        A_CLEAR: rdata_next = clear_reg;
        A_ACC_LABEL: rdata_next = label_reg;
        A_EXPECT: rdata_next = expect_reg;
        A_CR6: rdata_next = cr6_reg;
        A_CONTROL_REG_SIXTEEN: rdata_next = control_reg_sixteen_reg;
        A_FEBE_LO: rdata_next = febe_cnt_reg[7:0];
        A_FEBE_HI: rdata_next = febe_cnt_reg[15:8];
        A_B3_LO: rdata_next = b3_cnt_reg[7:0];
        A_B3_HI: rdata_next = b3_cnt_reg[15:8];
        A_SR3: begin
          rdata_next[SR3_EBER] = excess_path_error_alarm;
          rdata_next[SR3_MISMATCH] = label_mismatch_alarm;
          rdata_next[SR3_UNEQ] = unequipped_label_alarm;
          rdata_next[SR3_MF_LOSS] = multiframe_loss_alarm;
        end
        A_SR6: rdata_next[SR6_PDI] = payload_defect_label_alarm;
        A_SR7: begin
          rdata_next[SR7_B3_OVF] = b3_ovf_reg;
          rdata_next[SR7_FEBE_OVF] = febe_ovf_reg;
        end
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      block_size_reg <= RST_BLOCK_SIZE;
      window_reg <= RST_WINDOW;
      thresh_reg <= RST_THRESH;
      declare_reg <= RST_DECLARE;
      clear_reg <= RST_CLEAR;
      expect_reg <= RST_EXPECT;
      cr6_reg <= RST_CR6;
      control_reg_sixteen_reg <= RST_CONTROL_REG_SIXTEEN;
      rdata_reg <= 8'h00;
    end else begin
      block_size_reg <= block_size_next;
      window_reg <= window_next;
      thresh_reg <= thresh_next;
      declare_reg <= declare_next;
      clear_reg <= clear_next;
      expect_reg <= expect_next;
      cr6_reg <= cr6_next;
      control_reg_sixteen_reg <= control_reg_sixteen_next;
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************************
  // Parity, counters and excess error monitor
  // ****************************************************
  // defect precedence
  assign inhibit = line_defect | path_defect;
  assign wide = control_reg_sixteen_reg[CONTROL_REG_SIXTEEN_WIDE];
  assign local_mf = cr6_reg[CR6_LOCAL_MF];
  assign wr_b3 = reg_wr & ((reg_addr == A_B3_LO) | (reg_addr == A_B3_HI));
  assign wr_febe = reg_wr &
                   ((reg_addr == A_FEBE_LO) | (reg_addr == A_FEBE_HI));
  assign rd_sr7 = reg_rd & (reg_addr == A_SR7);
  assign diff = b3_data ^ bip_prev_reg;
  assign diff_pop = 4'($countones(diff));
  // far-end field, invalid codes count zero
  assign febe_inc = (g1_data[7:4] > FAR_END_MAX) ? 4'h0 : g1_data[7:4];
  assign blk_len = 28'(block_size_reg[3:0]) * 28'(pow10(control_reg_sixteen_reg[2:0]));
  assign blk_wide = 9'(blk_err_reg) + 9'(errs_reg);
  assign blk_sum = blk_wide[8] ? 8'hff : blk_wide[7:0];
  assign bad = blk_sum >= {4'h0, thresh_reg[7:4]};
  assign good = blk_sum < {4'h0, thresh_reg[3:0]};
  assign b3_add = sat_add(wr_b3 ? 16'h0000 : b3_cnt_reg, errs_reg, wide);
  assign febe_add = sat_add(wr_febe ? 16'h0000 : febe_cnt_reg,
                            (g1_valid & ~inhibit) ? febe_inc : 4'h0, wide);

  always_comb begin
    bip_acc_next = bip_acc_reg;
    bip_prev_next = bip_prev_reg;
    bip_ok_next = bip_ok_reg;
    stb_next = 1'b0;
    errs_next = errs_reg;
    b3_cnt_next = wr_b3 ? 16'h0000 : b3_cnt_reg;
    b3_ovf_next = b3_ovf_reg & ~rd_sr7;
    febe_cnt_next = febe_add[15:0];
    // far-end overflow, set wins over read clear
    febe_ovf_next = (febe_ovf_reg & ~rd_sr7) | febe_add[16];
    frame_cnt_next = frame_cnt_reg;
    blk_err_next = blk_err_reg;
    blk_cnt_next = blk_cnt_reg;
    bad_cnt_next = bad_cnt_reg;
    good_cnt_next = good_cnt_reg;
    eber_next = eber_reg;
    if (frame_start) begin
      bip_prev_next = bip_acc_reg;
      bip_ok_next = 1'b1;
      bip_acc_next = spe_valid ? spe_data : 8'h00;
    end else if (spe_valid) begin
      bip_acc_next = bip_acc_reg ^ spe_data;
    end
    if (b3_valid & bip_ok_reg) begin
      stb_next = 1'b1;
      errs_next = inhibit ? 4'h0 : diff_pop;
    end
    if (stb_reg) begin
      b3_cnt_next = b3_add[15:0];
      b3_ovf_next = (b3_ovf_reg & ~rd_sr7) | b3_add[16];
      blk_err_next = blk_sum;
      frame_cnt_next = frame_cnt_reg + 28'h0000001;
      if ((frame_cnt_reg + 28'h0000001) >= blk_len) begin
        frame_cnt_next = 28'h0000000;
        blk_err_next = 8'h00;
        bad_cnt_next = bad_cnt_reg + {7'h00, bad};
        good_cnt_next = good_cnt_reg + {7'h00, good};
        if (bad & ((bad_cnt_reg + 8'h01) >= declare_reg)) begin
          eber_next = 1'b1;
        end
        if (good & ((good_cnt_reg + 8'h01) >= clear_reg)) begin
          eber_next = 1'b0;
        end
        blk_cnt_next = blk_cnt_reg + 8'h01;
        if ((blk_cnt_reg + 8'h01) >= window_reg) begin
          blk_cnt_next = 8'h00;
          bad_cnt_next = 8'h00;
          good_cnt_next = 8'h00;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bip_acc_reg <= 8'h00;
      bip_prev_reg <= 8'h00;
      bip_ok_reg <= 1'b0;
      stb_reg <= 1'b0;
      errs_reg <= 4'h0;
      b3_cnt_reg <= 16'h0000;
      b3_ovf_reg <= 1'b0;
      febe_cnt_reg <= 16'h0000;
      febe_ovf_reg <= 1'b0;
      frame_cnt_reg <= 28'h0000000;
      blk_err_reg <= 8'h00;
      blk_cnt_reg <= 8'h00;
      bad_cnt_reg <= 8'h00;
      good_cnt_reg <= 8'h00;
      eber_reg <= 1'b0;
    end else begin
      bip_acc_reg <= bip_acc_next;
      bip_prev_reg <= bip_prev_next;
      bip_ok_reg <= bip_ok_next;
      stb_reg <= stb_next;
      errs_reg <= errs_next;
      b3_cnt_reg <= b3_cnt_next;
      b3_ovf_reg <= b3_ovf_next;
      febe_cnt_reg <= febe_cnt_next;
      febe_ovf_reg <= febe_ovf_next;
      frame_cnt_reg <= frame_cnt_next;
      blk_err_reg <= blk_err_next;
      blk_cnt_reg <= blk_cnt_next;
      bad_cnt_reg <= bad_cnt_next;
      good_cnt_reg <= good_cnt_next;
      eber_reg <= eber_next;
    end
  end

  // ****************************************************
  // Signal label and multiframe
  // ****************************************************
  // all-zero label
  assign uneq = label_ok_reg & (label_reg == LABEL_UNEQ);
  assign pdi = label_ok_reg & (label_reg >= LABEL_PDI_LO) &
               (label_reg <= LABEL_PDI_HI);
  assign mism = label_ok_reg & ~uneq & (label_reg != expect_reg);

  always_comb begin
    cand_next = cand_reg;
    rep_next = rep_reg;
    label_next = label_reg;
    label_ok_next = label_ok_reg;
    mf_state_next = mf_state_reg;
    mf_cnt_next = mf_cnt_reg;
    mf_cand_next = mf_cand_reg;
    h4v_next = h4_valid;
    h4_next = h4_reg;
    if (c2_valid) begin
      if ((c2_data == cand_reg) & (rep_reg != 3'h0)) begin
        if (rep_reg < LABEL_REPEATS + 3'h1) begin
          rep_next = rep_reg + 3'h1;
        end
        if (rep_reg == LABEL_REPEATS) begin
          label_next = c2_data;
          label_ok_next = 1'b1;
        end
      end else begin
        cand_next = c2_data;
        rep_next = 3'h1;
      end
    end
    case (mf_state_reg)
      MF_OFF: begin
        mf_cnt_next = 2'h0;
        if (local_mf) begin
          mf_state_next = MF_SYNC;
        end
      end
      MF_SYNC: begin
        if (h4_valid) begin
          mf_cnt_next = mf_cnt_reg + 2'h1;
          if (h4_data[1:0] != mf_cnt_reg + 2'h1) begin
            mf_state_next = MF_LOSS;
            mf_cand_next = h4_data[1:0];
          end
        end
      end
      MF_LOSS: begin
        if (h4_valid) begin
          mf_cnt_next = mf_cnt_reg + 2'h1;
          mf_cand_next = h4_data[1:0];
          if ((h4_data[1:0] == mf_cnt_reg + 2'h1) |
              (h4_data[1:0] == mf_cand_reg + 2'h1)) begin
            mf_cnt_next = h4_data[1:0];
            mf_state_next = MF_SYNC;
          end
        end
      end
      default: mf_state_next = MF_OFF;
    endcase
    if (!local_mf) begin
      mf_state_next = MF_OFF;
    end
    if (h4_valid) begin
      h4_next = local_mf ? {h4_data[7:2], mf_cnt_next} : h4_data;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cand_reg <= 8'h00;
      rep_reg <= 3'h0;
      label_reg <= 8'h00;
      label_ok_reg <= 1'b0;
      mf_state_reg <= MF_OFF;
      mf_cnt_reg <= 2'h0;
      mf_cand_reg <= 2'h0;
      h4v_reg <= 1'b0;
      h4_reg <= 8'h00;
    end else begin
      cand_reg <= cand_next;
      rep_reg <= rep_next;
      label_reg <= label_next;
      label_ok_reg <= label_ok_next;
      mf_state_reg <= mf_state_next;
      mf_cnt_reg <= mf_cnt_next;
      mf_cand_reg <= mf_cand_next;
      h4v_reg <= h4v_next;
      h4_reg <= h4_next;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign reg_rdata = rdata_reg;
  assign far_end_err_stb = stb_reg;
  assign far_end_err_count = errs_reg;
  assign h4_out_valid = h4v_reg;
  assign h4_out = h4_reg;
  assign mf_phase = mf_cnt_reg;
  // timing part only with local generation
  assign mf_v1_en = local_mf & (mf_state_reg != MF_OFF);
  assign excess_path_error_alarm = eber_reg & ~inhibit;
  assign label_mismatch_alarm = mism & ~inhibit;
  assign unequipped_label_alarm = uneq & ~inhibit;
  assign payload_defect_label_alarm = pdi & ~inhibit;
  assign multiframe_loss_alarm = (mf_state_reg == MF_LOSS) & local_mf &
                                 ~inhibit;

endmodule : rpm_monitor

// [verif/rpm_far.sv]
// Far-side model: receive line processor feeding overhead bytes
`timescale 1ns/1ps
// ****************************************************
// Frame source
// ****************************************************
module rpm_far (
  input wire logic mclk,
  output logic frame_start,
  output logic spe_valid,
  output logic [7:0] spe_data,
  output logic b3_valid,
  output logic [7:0] b3_data,
  output logic c2_valid,
  output logic [7:0] c2_data,
  output logic h4_valid,
  output logic [7:0] h4_data,
  output logic g1_valid,
  output logic [7:0] g1_data
);
  logic [7:0] par;
  initial begin
    {frame_start, spe_valid, b3_valid, c2_valid, h4_valid, g1_valid} = '0;
    {spe_data, b3_data, c2_data, h4_data, g1_data} = '0;
    par = 8'h00;
  end
  task send(input logic [7:0] m, c, h, g);
    logic [7:0] p;
    logic [7:0] b;
    p = 8'h00;
    for (int k = 0; k < 10; k++) begin
      @(posedge mclk);
      b = 8'h5a ^ 8'(k);
      if (k < 3)
        p = p ^ b;
      frame_start <= (k == 0);
      spe_valid <= (k < 3);
      spe_data <= (k < 3) ? b : ~spe_data;
      b3_valid <= (k == 3);
      b3_data <= (k == 3) ? par ^ m : ~b3_data;
      c2_valid <= (k == 4);
      c2_data <= (k == 4) ? c : ~c2_data;
      h4_valid <= (k == 5);
      h4_data <= (k == 5) ? h : ~h4_data;
      g1_valid <= (k == 6);
      g1_data <= (k == 6) ? g : ~g1_data;
    end
    par = p;
  endtask : send
endmodule : rpm_far

// [verif/rpm_monitor_chk.sv]
// Port checker of the receive path overhead monitor
`timescale 1ns/1ps
// ****************************************************
// Checker
// ****************************************************
module rpm_monitor_chk (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic b3_valid,
  input wire logic h4_valid,
  input wire logic [7:0] h4_data,
  input wire logic line_defect,
  input wire logic path_defect,
  input wire logic far_end_err_stb,
  input wire logic [3:0] far_end_err_count,
  input wire logic h4_out_valid,
  input wire logic [7:0] h4_out,
  input wire logic mf_v1_en,
  input wire logic excess_path_error_alarm,
  input wire logic label_mismatch_alarm,
  input wire logic unequipped_label_alarm,
  input wire logic payload_defect_label_alarm,
  input wire logic multiframe_loss_alarm
);
  logic dfct;
  assign dfct = line_defect | path_defect;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  a_stb_cause: assert property (far_end_err_stb |-> $past(b3_valid))
    else $error("error strobe without parity byte");
  a_err_range: assert property (far_end_err_stb |->
    far_end_err_count <= 4'h8)
    else $error("frame error count above eight");
  a_h4_echo: assert property (h4_valid |=> h4_out_valid &&
    ((h4_out ^ $past(h4_data)) & 8'hfc) == 8'h00)
    else $error("multiframe byte not echoed");
  a_h4_pass: assert property (h4_valid && !mf_v1_en |=>
    h4_out == $past(h4_data))
    else $error("pass-through multiframe byte altered");
  a_pass_idle: assert property (!mf_v1_en && !$past(mf_v1_en) |->
    !multiframe_loss_alarm)
    else $error("multiframe loss in pass-through");
  a_defect_mask: assert property (dfct |->
    !(excess_path_error_alarm ||
    label_mismatch_alarm || unequipped_label_alarm ||
    payload_defect_label_alarm || multiframe_loss_alarm))
    else $error("path alarm under defect");
  a_mis_excl: assert property (label_mismatch_alarm |->
    !unequipped_label_alarm)
    else $error("mismatch with unequipped");
  a_eber_tick: assert property ($changed(excess_path_error_alarm) &&
    $stable(dfct) |-> $past(far_end_err_stb))
    else $error("excess alarm moved off frame tick");
  a_loss_cause: assert property ($rose(multiframe_loss_alarm) &&
    $stable(dfct) |-> $past(h4_valid))
    else $error("multiframe loss without byte");
endmodule : rpm_monitor_chk
bind rpm_monitor rpm_monitor_chk i_rpm_monitor_chk (.mclk, .rstn, .b3_valid,
  .h4_valid, .h4_data, .line_defect, .path_defect, .far_end_err_stb,
  .far_end_err_count, .h4_out_valid, .h4_out, .mf_v1_en,
  .excess_path_error_alarm, .label_mismatch_alarm, .unequipped_label_alarm,
  .payload_defect_label_alarm, .multiframe_loss_alarm);

// [verif/rpm_monitor_tb.sv]
// Self-checking bench of the receive path overhead monitor
`timescale 1ns/1ps
// ****************************************************
// Bench
// ****************************************************
module rpm_monitor_tb
  import rpm_pkg::*;
;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0, line_defect = 1'b0, path_defect = 1'b0;
  logic frame_start, spe_valid, b3_valid, c2_valid, h4_valid, g1_valid;
  logic [7:0] spe_data, b3_data, c2_data, h4_data, g1_data, reg_rdata, h4_out;
  logic [7:0] v;
  logic far_end_err_stb, h4_out_valid, mf_v1_en;
  logic [3:0] far_end_err_count;
  logic [1:0] mf_phase;
  logic excess_path_error_alarm, label_mismatch_alarm, unequipped_label_alarm;
  logic payload_defect_label_alarm, multiframe_loss_alarm;
  int n_fail = 0, num_checks = 0, cyc = 0, n_stb = 0;
  always #12.5 mclk = ~mclk;
  rpm_monitor i_rpm_monitor (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .frame_start, .spe_valid, .spe_data, .b3_valid,
    .b3_data, .c2_valid, .c2_data, .h4_valid, .h4_data, .g1_valid, .g1_data,
    .line_defect, .path_defect, .far_end_err_stb, .far_end_err_count,
    .h4_out_valid, .h4_out, .mf_phase, .mf_v1_en, .excess_path_error_alarm,
    .label_mismatch_alarm, .unequipped_label_alarm,
    .payload_defect_label_alarm, .multiframe_loss_alarm);
  rpm_far i_rpm_far (.mclk, .frame_start, .spe_valid, .spe_data, .b3_valid,
    .b3_data, .c2_valid, .c2_data, .h4_valid, .h4_data, .g1_valid, .g1_data);
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (far_end_err_stb)
      n_stb <= n_stb + 1;
    if (cyc == 8000) begin
      n_fail++;
      conclude();
    end
  end
  task chk(input logic [7:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task rchk(input logic [7:0] a, m, e);
    rd(a);
    chk(v & m, e);
  endtask : rchk
  task frames(input int n, input logic [7:0] m, c, h, g);
    for (int i = 0; i < n; i++)
      i_rpm_far.send(m, c, h + 8'(i), g);
    #1;
  endtask : frames
  task t_regs;
    rchk(A_BLOCK_SIZE, 8'hff, 8'h05);
    rchk(A_WINDOW, 8'hff, 8'h40);
    rchk(A_THRESH, 8'hff, 8'h42);
    rchk(A_DECLARE, 8'hff, 8'h10);
    rchk(A_CLEAR, 8'hff, 8'h1d);
    rchk(A_CONTROL_REG_SIXTEEN, 8'h07, 8'h01);
    rchk(A_CR6, 8'h20, 8'h00);
    wr(A_BLOCK_SIZE, 8'hf7);
    rchk(A_BLOCK_SIZE, 8'hff, 8'h07);
    wr(8'h10, 8'h5a);
    rchk(8'h10, 8'hff, 8'h00);
    $display("registers done");
  endtask : t_regs
  task t_parity;
    frames(1, 8'h00, 8'h02, 8'h00, 8'h00);
    wr(A_B3_LO, 8'h00);
    frames(1, 8'h01, 8'h02, 8'h00, 8'h00);
    chk({4'h0, far_end_err_count}, 8'h01);
    frames(1, 8'h0c, 8'h02, 8'h00, 8'h00);
    chk({4'h0, far_end_err_count}, 8'h02);
    frames(1, 8'h00, 8'h02, 8'h00, 8'h00);
    chk({4'h0, far_end_err_count}, 8'h00);
    rchk(A_B3_LO, 8'hff, 8'h03);
    @(posedge mclk);
    path_defect <= 1'b1;
    frames(1, 8'h03, 8'h02, 8'h00, 8'h00);
    chk({4'h0, far_end_err_count}, 8'h00);
    rchk(A_B3_LO, 8'hff, 8'h03);
    chk(8'(n_stb), 8'h05);
    @(posedge mclk);
    path_defect <= 1'b0;
    $display("parity done");
  endtask : t_parity
  task t_eber;
    wr(A_BLOCK_SIZE, 8'h01);
    wr(A_CONTROL_REG_SIXTEEN, 8'h00);
    wr(A_WINDOW, 8'h04);
    wr(A_THRESH, 8'h21);
    wr(A_DECLARE, 8'h02);
    wr(A_CLEAR, 8'h02);
    frames(4, 8'h00, 8'h02, 8'h00, 8'h00);
    chk({7'h0, excess_path_error_alarm}, 8'h00);
    frames(4, 8'h01, 8'h02, 8'h00, 8'h00);
    chk({7'h0, excess_path_error_alarm}, 8'h00);
    frames(4, 8'h03, 8'h02, 8'h00, 8'h00);
    chk({7'h0, excess_path_error_alarm}, 8'h01);
    rchk(A_SR3, 8'h10, 8'h10);
    @(posedge mclk);
    line_defect <= 1'b1;
    #1 chk({7'h0, excess_path_error_alarm}, 8'h00);
    @(posedge mclk);
    line_defect <= 1'b0;
    frames(4, 8'h01, 8'h02, 8'h00, 8'h00);
    chk({7'h0, excess_path_error_alarm}, 8'h01);
    frames(4, 8'h00, 8'h02, 8'h00, 8'h00);
    chk({7'h0, excess_path_error_alarm}, 8'h00);
    $display("excess error done");
  endtask : t_eber
  task t_label;
    wr(A_EXPECT, 8'h02);
    frames(5, 8'h00, 8'h02, 8'h00, 8'h00);
    chk({5'h0, label_mismatch_alarm, unequipped_label_alarm,
      payload_defect_label_alarm}, 8'h00);
    frames(4, 8'h00, 8'h05, 8'h00, 8'h00);
    chk({7'h0, label_mismatch_alarm}, 8'h00);
    frames(1, 8'h00, 8'h05, 8'h00, 8'h00);
    chk({7'h0, label_mismatch_alarm}, 8'h01);
    rchk(A_ACC_LABEL, 8'hff, 8'h05);
    rchk(A_SR3, 8'h06, 8'h04);
    frames(5, 8'h00, 8'h00, 8'h00, 8'h00);
    chk({5'h0, label_mismatch_alarm, unequipped_label_alarm,
      payload_defect_label_alarm}, 8'h02);
    rchk(A_SR3, 8'h06, 8'h02);
    frames(5, 8'h00, 8'he1, 8'h00, 8'h00);
    chk({7'h0, payload_defect_label_alarm}, 8'h01);
    rchk(A_SR6, 8'h10, 8'h10);
    $display("label done");
  endtask : t_label
  task t_mf;
    chk({7'h0, mf_v1_en}, 8'h00);
    wr(A_CR6, 8'h20);
    @(posedge mclk);
    #1 chk({7'h0, mf_v1_en}, 8'h01);
    frames(8, 8'h00, 8'h02, 8'h40, 8'h00);
    chk({7'h0, multiframe_loss_alarm}, 8'h00);
    chk({6'h0, mf_phase}, 8'h03);
    frames(1, 8'h00, 8'h02, 8'h42, 8'h00);
    chk({7'h0, multiframe_loss_alarm}, 8'h01);
    wr(A_CR6, 8'h00);
    frames(1, 8'h00, 8'h02, 8'h00, 8'h00);
    chk({7'h0, multiframe_loss_alarm}, 8'h00);
    chk({6'h0, mf_phase}, 8'h00);
    $display("multiframe done");
  endtask : t_mf
  task t_far;
    rd(A_SR7);
    wr(A_FEBE_LO, 8'h00);
    frames(2, 8'h00, 8'h02, 8'h00, 8'h30);
    rchk(A_FEBE_LO, 8'hff, 8'h06);
    frames(1, 8'h00, 8'h02, 8'h00, 8'h90);
    rchk(A_FEBE_LO, 8'hff, 8'h06);
    wr(A_B3_LO, 8'h00);
    frames(32, 8'hff, 8'h02, 8'h00, 8'h80);
    rchk(A_FEBE_LO, 8'hff, 8'hff);
    rchk(A_B3_LO, 8'hff, 8'hff);
    rchk(A_SR7, 8'h90, 8'h90);
    rchk(A_SR7, 8'h90, 8'h00);
    $display("far end done");
  endtask : t_far
  initial begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    t_regs();
    t_parity();
    t_eber();
    t_label();
    t_mf();
    t_far();
    conclude();
  end
endmodule : rpm_monitor_tb
